// ---- bench/mmu_translate_and_check_test.sv ----
// self-checking bench for the translation and permission unit
`timescale 1ns/10ps
`default_nettype none
module mmu_translate_and_check_test;
    import mmu_pkg::*;
    logic clk, rst_n, req, ready_r, done_r, abort_r, cach_r, buf_r;
    logic walk_req_r, walk_ack, coproc_write_op, coproc_read_op;
    logic cp_rvalid_r;
    logic [31:0] pa_r, walk_addr_r, walk_rdata, cp_wdata, cp_rdata_r;
    logic [2:0] cp_reg;
    logic [3:0] delay;
    access_t acc;
    int num_errors = 0;
    int n_compared = 0;

    mmu_translate_and_check #(.ENTRIES(4)) i_mmu_translate_and_check (
        .clk(clk), .rst_n(rst_n), .req(req), .acc_in(acc),
        .ready_r(ready_r), .done_r(done_r), .abort_r(abort_r),
        .pa_r(pa_r), .cach_r(cach_r), .buf_r(buf_r),
        .walk_req_r(walk_req_r), .walk_addr_r(walk_addr_r),
        .walk_rdata(walk_rdata), .walk_ack(walk_ack),
        .coproc_write_op(coproc_write_op),
        .coproc_read_op(coproc_read_op), .cp_reg(cp_reg),
        .cp_wdata(cp_wdata), .cp_rdata_r(cp_rdata_r),
        .cp_rvalid_r(cp_rvalid_r));
    table_mem_model i_table_mem_model (
        .clk(clk), .rst_n(rst_n), .walk_req_r(walk_req_r),
        .walk_addr_r(walk_addr_r), .delay(delay),
        .walk_rdata(walk_rdata), .walk_ack(walk_ack));

    always #12.5 clk = ~clk;

    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    // expected level-one address with the table based at 0x0004_0000
    function automatic logic [31:0] l1a(input logic [31:0] va);
        return {18'h00010, va[31:20], 2'b00};
    endfunction : l1a

    function automatic logic [31:0] sec(input logic [11:0] pb,
        input logic [1:0] pc, input logic [3:0] dom);
        return {pb, 8'h00, pc, 1'b0, dom, 1'b1, 2'b11, 2'b10};
    endfunction : sec

    function automatic logic ok_perm(input logic [1:0] pc, sr,
        input logic u, w);
        case (pc)
            2'h0: return sr == 2'h1 ? !u && !w : sr == 2'h2 ? !w : 1'b0;
            2'h1: return !u;
            2'h2: return !u || !w;
            default: return 1'b1;
        endcase
    endfunction : ok_perm

    task automatic cp(input logic wr, input logic [2:0] r,
        input logic [31:0] d);
        @(posedge clk);
        coproc_write_op <= wr;
        coproc_read_op <= !wr;
        cp_reg <= r;
        cp_wdata <= d;
        @(posedge clk);
        coproc_write_op <= 1'b0;
        coproc_read_op <= 1'b0;
        #1;
    endtask : cp

    task automatic rd(input logic [2:0] r, input logic [31:0] exp);
        cp(1'b0, r, 32'h0);
        check(cp_rvalid_r, 32'h1);
        check(cp_rdata_r, exp);
    endtask : rd

    // nw < 0 skips the fetch count
    task automatic access(input logic [31:0] va, input logic w, u, d,
        input logic ok, input logic [31:0] pa, input int nw);
        int n;
        int f0;
        f0 = i_table_mem_model.fetches;
        @(posedge clk);
        req <= 1'b1;
        acc <= '{va: va, write: w, user: u, data: d};
        @(posedge clk);
        req <= 1'b0;
        #1;
        n = 0;
        while (done_r !== 1'b1 && abort_r !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(done_r, ok);
        check(abort_r, !ok);
        if (ok) check(pa_r, pa);
        check(ready_r, 32'h1);
        if (nw >= 0) check(i_table_mem_model.fetches - f0, nw);
    endtask : access

    task automatic t_off;
        access(32'h1234_5678, 1'b1, 1'b1, 1'b1, 1'b1, 32'h1234_5678, 0);
        check(cach_r, 32'h0);
        rd(CP_FAULT, 32'h0);
        rd(CP_SETUP, 32'h0);
        rd(3'h7, 32'h0);
        cp(1'b1, CP_ROOT, 32'h0004_3fff);
        cp(1'b1, CP_ZONE, 32'h4000_008d);
        cp(1'b1, CP_SETUP, 32'h0000_000d);
    endtask : t_off

    task automatic t_section;
        i_table_mem_model.mem[l1a(32'h3450_0000)] = sec(12'habc, 2'h3, 4'h0);
        access(32'h3450_0abc, 1'b1, 1'b1, 1'b1, 1'b1, 32'habc0_0abc, 1);
        check(i_table_mem_model.last_addr, l1a(32'h3450_0000));
        check({cach_r, buf_r}, 32'h3);
        access(32'h345f_fff0, 1'b0, 1'b1, 1'b1, 1'b1, 32'habcf_fff0, 0);
        cp(1'b1, CP_SETUP, 32'h0000_0001);
        access(32'h3450_0004, 1'b0, 1'b0, 1'b1, 1'b1, 32'habc0_0004, 0);
        check({cach_r, buf_r}, 32'h0);
    endtask : t_section

    task automatic t_perm;
        logic [31:0] va;
        for (int q = 0; q < 4; q++) begin
            va = {12'h400 + 12'(q), 20'h00123};
            i_table_mem_model.mem[l1a(va)] = sec(12'h800 + 12'(q),
                2'(q), 4'hf);
        end
        for (int sr = 0; sr < 4; sr++) begin
            cp(1'b1, CP_SETUP, 32'h0000_000d | (32'(sr) << 8));
            for (int k = 0; k < 16; k++) begin
                va = {12'h400 + 12'(k >> 2), 20'h00123};
                access(va, k[0], k[1], 1'b1, ok_perm(2'(k >> 2), 2'(sr),
                    k[1], k[0]), {12'h800 + 12'(k >> 2), 20'h00123},
                    -1);
            end
        end
        cp(1'b1, CP_SETUP, 32'h0000_000d);
    endtask : t_perm

    task automatic t_domain;
        for (int d = 1; d < 4; d++)
            i_table_mem_model.mem[l1a({12'h700 + 12'(d), 20'h0})] =
                sec(12'h900 + 12'(d), 2'h0, 4'(d));
        access(32'h7010_0040, 1'b1, 1'b1, 1'b1, 1'b1, 32'h9010_0040, 1);
        access(32'h7020_0080, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0, 1);
        rd(CP_FAULT, 32'h0000_0029);
        rd(CP_VADDR, 32'h7020_0080);
        access(32'h7030_0000, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 1);
        rd(CP_FAULT, 32'h0000_0029);
        rd(CP_VADDR, 32'h7020_0080);
        access(32'h7030_0010, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0, -1);
        rd(CP_FAULT, 32'h0000_0039);
    endtask : t_domain

    task automatic t_flush;
        logic [31:0] va;
        cp(1'b1, CP_FAULT, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            va = {12'h500 + 12'(i), 20'h0};
            i_table_mem_model.mem[l1a(va)] = sec(12'ha00 + 12'(i), 2'h3, 4'h0);
            access(va, 1'b0, 1'b0, 1'b1, 1'b1, {12'ha00 + 12'(i), 20'h0}, 1);
        end
        access(32'h5000_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha000_0000, 1);
        access(32'h5020_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha020_0000, 0);
        access(32'h5010_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha010_0000, 1);
        cp(1'b1, CP_VADDR, 32'h5000_0fff);
        access(32'h5000_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha000_0000, 1);
        access(32'h5010_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha010_0000, 0);
        cp(1'b1, CP_FAULT, 32'h0);
        access(32'h5000_0000, 1'b0, 1'b0, 1'b1, 1'b1, 32'ha000_0000, 1);
    endtask : t_flush

    // small page quarter 1 is supervisor only; large page quarter 3 code 00
    task automatic t_page;
        delay <= 4'h3;
        i_table_mem_model.mem[l1a(32'h6000_0000)] = 32'h0008_0411;
        i_table_mem_model.mem[32'h0008_0404] = 32'h9abc_df72;
        i_table_mem_model.mem[32'h0008_0480] = 32'h7777_03f1;
        access(32'h6000_1000, 1'b0, 1'b1, 1'b1, 1'b1, 32'h9abc_d000, 2);
        access(32'h6000_1400, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0, 0);
        access(32'h6000_1400, 1'b1, 1'b0, 1'b1, 1'b1, 32'h9abc_d400, 0);
        access(32'h6002_0abc, 1'b0, 1'b1, 1'b1, 1'b1, 32'h7777_0abc, 2);
        access(32'h6002_c000, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0, 0);
        cp(1'b1, CP_SETUP, 32'h0);
        access(32'h6002_c000, 1'b1, 1'b1, 1'b0, 1'b1, 32'h6002_c000, 0);
    endtask : t_page

    initial begin
        #500000;
        num_errors++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req = 1'b0;
        acc = '0;
        coproc_write_op = 1'b0;
        coproc_read_op = 1'b0;
        cp_reg = 3'h0;
        cp_wdata = 32'h0;
        delay = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_off();
        t_section();
        t_perm();
        t_domain();
        t_flush();
        t_page();
        finish_test();
    end
endmodule : mmu_translate_and_check_test
`default_nettype wire

// ---- bench/table_mem_model.sv ----
// table memory model answering the unit's descriptor fetches
`timescale 1ns/10ps
`default_nettype none
module table_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic walk_req_r,
    input wire logic [31:0] walk_addr_r,
    input wire logic [3:0] delay,
    output logic [31:0] walk_rdata,
    output logic walk_ack
);
    logic [31:0] mem [logic [31:0]];
    logic [3:0] cnt;
    logic [31:0] last_addr;
    int fetches;
    // released data is inverted so a late sample cannot pass by luck
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            walk_ack <= 1'b0;
            walk_rdata <= 32'h5a5a_a5a5;
            cnt <= 4'h0;
            fetches <= 0;
            last_addr <= 32'h0;
        end else if (walk_ack) begin
            walk_ack <= 1'b0;
            walk_rdata <= ~walk_rdata;
        end else if (walk_req_r && cnt == delay) begin
            walk_ack <= 1'b1;
            walk_rdata <= mem[walk_addr_r];
            last_addr <= walk_addr_r;
            fetches <= fetches + 1;
            cnt <= 4'h0;
        end else if (walk_req_r) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : table_mem_model
`default_nettype wire

// ---- pkg/mmu_pkg.sv ----
// constants, types and register layout for the translation unit
package mmu_pkg;
    // coprocessor register numbers
    localparam logic [2:0] CP_SETUP = 3'h1;
    localparam logic [2:0] CP_ROOT = 3'h2;
    localparam logic [2:0] CP_ZONE = 3'h3;
    localparam logic [2:0] CP_FAULT = 3'h5;
    localparam logic [2:0] CP_VADDR = 3'h6;
    // setup register bits
    localparam int SET_M = 0;
    localparam int SET_C = 2;
    localparam int SET_W = 3;
    localparam int SET_S = 8;
    localparam int SET_R = 9;
    localparam logic [31:0] SETUP_RST = 32'h0000_0000;
    localparam logic [31:0] ROOT_RST = 32'h0000_0000;
    localparam logic [31:0] ZONE_RST = 32'h0000_0000;
    // address fields
    localparam int ROOT_LSB = 14;
    localparam int SEC_LSB = 20;
    localparam int TAG_LSB = 12;
    localparam int SUB_SMALL_LSB = 10;
    localparam int SUB_LARGE_LSB = 14;
    localparam int PTBL_LSB = 10;
    localparam logic [1:0] WORD_PAD = 2'h0;
    localparam logic [19:0] SEC_MASK = 20'hfff00;
    localparam logic [19:0] LARGE_MASK = 20'hffff0;
    localparam logic [19:0] SMALL_MASK = 20'hfffff;
    // descriptor fields
    localparam int L1_SECT_BIT = 1;
    localparam int L1_PAGE_BIT = 0;
    localparam int DESC_B = 2;
    localparam int DESC_C = 3;
    localparam int DESC_DOM_LSB = 5;
    localparam int DESC_PERM_LSB = 10;
    localparam int L2_PERM_LSB = 4;
    localparam logic [1:0] L2_LARGE = 2'h1;
    localparam logic [1:0] L2_SMALL = 2'h2;
    // domain and permission codes
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_MGR = 2'h3;
    localparam logic [1:0] PERM_00 = 2'h0;
    localparam logic [1:0] PERM_01 = 2'h1;
    localparam logic [1:0] PERM_10 = 2'h2;
    localparam logic [1:0] PERM_11 = 2'h3;
    // fault cause codes and layout
    localparam int CAUSE_W = 8;
    localparam logic [3:0] FS_TRANS_SEC = 4'h5;
    localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
    localparam logic [3:0] FS_DOM_SEC = 4'h9;
    localparam logic [3:0] FS_DOM_PAGE = 4'hb;
    localparam logic [3:0] FS_PERM_SEC = 4'hd;
    localparam logic [3:0] FS_PERM_PAGE = 4'hf;

    typedef enum logic [1:0] {
        SZ_SEC = 2'h0,
        SZ_LARGE = 2'h1,
        SZ_SMALL = 2'h2
    } map_size_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_CHECK = 4'h2,
        S_L1 = 4'h4,
        S_L2 = 4'h8
    } walk_state_t;

    typedef struct packed {
        logic [31:0] va;
        logic write;
        logic user;
        logic data;
    } access_t;

    typedef struct packed {
        logic [19:0] tag;
        map_size_t size;
        logic [19:0] pbase;
        logic [7:0] perm_bits;
        logic [3:0] dom;
        logic cach;
        logic bufa;
    } tlb_entry_t;
endpackage : mmu_pkg

// ---- src/mmu_translate_and_check.sv ----
// address translation, table walk and permission check unit
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: map 1MB sections, 4kB small pages and 64kB large pages.
// R2: permissions per 1kB quarter of small, 16kB quarter of large pages.
// R3: 64-entry translation cache feeds the permission check.
// R4: hit checks permission; grant drives physical address, else abort.
// R5: miss walks table, fills cache; victim pointer steps round-robin.
// R6: when translation is off, virtual address passes through unchanged.
// R7: 32-bit registers reached only through coprocessor transfers.
// R8: table base low 14 bits forced to zero.
// R9: zone rights hold sixteen 2-bit domain fields.
// R10: fault cause holds domain in 7:4, fault code in 3:0.
// R11: any write to fault cause location flushes whole cache.
// R12: write to fault address location purges matching entry.
// R13: fault registers load on data faults only, never on prefetch.
// R14: level-one address is base 31:14 joined with va 31:20.
// R15: descriptor bit 1 selects section against page table.
// R16: section done after level one; pages need a level-two fetch.
// R17: descriptor C/B apply only when cache/write buffer enabled.
// R18: section bits 8:5 pick the governing domain field.
// R19: section bits 11:10 are the permission code, client domains only.
// R20: code 00 decoded with system and rom protect bits.
// R21: codes 01, 10, 11 grant rising supervisor/user access.
// R22: section physical address takes descriptor bits 31:20.
// R23: domain 00/10 faults, 01 checks code, 11 manager never faults.
// R24: a violation is caught before the memory access and blocks it.
// R25: all cache entries invalid after reset.
// R26: software writes section bit 4 one, bits 19:12 zero; ignored.
module mmu_translate_and_check
    import mmu_pkg::*;
#(
    parameter int ENTRIES = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire access_t acc_in,
    output logic ready_r,
    output logic done_r,
    output logic abort_r,
    output logic [31:0] pa_r,
    output logic cach_r,
    output logic buf_r,
    output logic walk_req_r,
    output logic [31:0] walk_addr_r,
    input wire logic [31:0] walk_rdata,
    input wire logic walk_ack,
    input wire logic coproc_write_op,
    input wire logic coproc_read_op,
    input wire logic [2:0] cp_reg,
    input wire logic [31:0] cp_wdata,
    output logic [31:0] cp_rdata_r,
    output logic cp_rvalid_r
);
    localparam int IDX_W = $clog2(ENTRIES);

    walk_state_t st_r, st_nxt;
    access_t acc_r, acc_nxt;
    logic [31:0] mmu_setup_r, table_base_pointer_r, zone_rights_r;
    logic [CAUSE_W-1:0] fault_cause_reg_r;
    logic [31:0] fault_vaddr_reg_r;
    tlb_entry_t tlb_r [ENTRIES];
    logic [ENTRIES-1:0] valid_r, valid_nxt, hit_vec, purge_vec, fill_vec;
    logic [IDX_W-1:0] victim_r, hit_idx;
    logic [3:0] l1_dom_r, l1dom_nxt, log_dom;
    logic done_nxt, abort_nxt, cach_nxt, buf_nxt, wreq_nxt;
    logic fill, log_en;
    logic [31:0] pa_nxt, waddr_nxt;
    logic [3:0] log_code;
    tlb_entry_t fill_e;

    function automatic logic tag_hit(tlb_entry_t e, logic [31:0] a);
        logic [19:0] m;
        m = (e.size == SZ_SEC) ? SEC_MASK :
            (e.size == SZ_LARGE) ? LARGE_MASK : SMALL_MASK; // R1
        return ((e.tag ^ a[31:TAG_LSB]) & m) == '0;
    endfunction : tag_hit

    // access allowed for a client domain
    function automatic logic perm_ok(logic [1:0] code, logic s, logic r,
                                     logic user, logic wr);
        logic ok;
        ok = 1'b0;
        case (code)
            PERM_00: begin
                if (s && !r)
                    ok = !user && !wr; // R20
                else if (r && !s)
                    ok = !wr; // R20
            end
            PERM_01: ok = !user; // R21
            PERM_10: ok = !user || !wr; // R21
            PERM_11: ok = 1'b1; // R21
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : perm_ok

    // lookup and purge compare, one comparator pair per entry
    for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
        assign hit_vec[i] = valid_r[i] && tag_hit(tlb_r[i], acc_r.va); // R3
        assign purge_vec[i] = valid_r[i] && tag_hit(tlb_r[i], cp_wdata);
    end

    always_comb begin
        hit_idx = '0;
        for (int k = ENTRIES - 1; k >= 0; k--) begin
            if (hit_vec[k])
                hit_idx = IDX_W'(k);
        end
    end

    wire logic hit = |hit_vec;
    wire tlb_entry_t he = tlb_r[hit_idx];
    wire logic mmu_on = mmu_setup_r[SET_M];
    wire logic is_sec = he.size == SZ_SEC;
    wire logic [1:0] sub_idx =
        (he.size == SZ_SMALL) ? acc_r.va[SUB_SMALL_LSB +: 2] :
        (he.size == SZ_LARGE) ? acc_r.va[SUB_LARGE_LSB +: 2] : 2'h0; // R2
    wire logic [1:0] perm = he.perm_bits[{sub_idx, 1'b0} +: 2]; // R2
    wire logic [1:0] dom_code = zone_rights_r[{he.dom, 1'b0} +: 2]; // R9
    // reserved domain code falls through to the no-access fault
    wire logic dom_fault = !dom_code[0]; // R23
    wire logic perm_fault = (dom_code == DOM_CLIENT) &&
        !perm_ok(perm, mmu_setup_r[SET_S], mmu_setup_r[SET_R],
                 acc_r.user, acc_r.write); // R19 R23
    wire logic [3:0] hit_code = dom_fault ?
        (is_sec ? FS_DOM_SEC : FS_DOM_PAGE) :
        (is_sec ? FS_PERM_SEC : FS_PERM_PAGE);
    wire logic [31:0] pa_calc =
        is_sec ? {he.pbase[19:8], acc_r.va[SEC_LSB-1:0]} : // R22
        (he.size == SZ_LARGE) ? {he.pbase[19:4], acc_r.va[15:0]} :
        {he.pbase, acc_r.va[TAG_LSB-1:0]}; // R1
    wire logic [31:0] l1_addr = {table_base_pointer_r[31:ROOT_LSB],
                                 acc_r.va[31:SEC_LSB], WORD_PAD}; // R14
    wire logic [31:0] l2_addr = {walk_rdata[31:PTBL_LSB],
                                 acc_r.va[SEC_LSB-1:TAG_LSB], WORD_PAD};
    wire logic [3:0] rd_dom = walk_rdata[DESC_DOM_LSB +: 4]; // R18
    // section bit 4 and bits 19:12 are not looked at
    wire tlb_entry_t l1_e = '{tag: acc_r.va[31:TAG_LSB], size: SZ_SEC,
        pbase: walk_rdata[31:TAG_LSB],
        perm_bits: {4{walk_rdata[DESC_PERM_LSB +: 2]}}, dom: rd_dom,
        cach: walk_rdata[DESC_C], bufa: walk_rdata[DESC_B]}; // R26
    wire logic [1:0] l2_type = walk_rdata[1:0];
    wire tlb_entry_t l2_e = '{tag: acc_r.va[31:TAG_LSB],
        size: (l2_type == L2_LARGE) ? SZ_LARGE : SZ_SMALL,
        pbase: walk_rdata[31:TAG_LSB],
        perm_bits: walk_rdata[L2_PERM_LSB +: 8],
        dom: l1_dom_r, cach: walk_rdata[DESC_C],
        bufa: walk_rdata[DESC_B]};

    wire logic cp_flush = coproc_write_op && cp_reg == CP_FAULT; // R11
    wire logic cp_purge = coproc_write_op && cp_reg == CP_VADDR; // R12
    wire logic [31:0] rd_val =
        (cp_reg == CP_FAULT) ? {{(32 - CAUSE_W){1'b0}}, fault_cause_reg_r} :
        (cp_reg == CP_VADDR) ? fault_vaddr_reg_r : '0; // R7

    assign fill_vec = fill ? (ENTRIES'(1) << victim_r) : '0; // R5
    // a flush overrides a fill landing the same cycle
    assign valid_nxt = cp_flush ? '0 :
        ((valid_r & ~(cp_purge ? purge_vec : '0)) | fill_vec); // R11 R12

    always_comb begin
        st_nxt = st_r;
        acc_nxt = acc_r;
        done_nxt = 1'b0;
        abort_nxt = 1'b0;
        pa_nxt = pa_r;
        cach_nxt = cach_r;
        buf_nxt = buf_r;
        wreq_nxt = walk_req_r;
        waddr_nxt = walk_addr_r;
        l1dom_nxt = l1_dom_r;
        fill = 1'b0;
        fill_e = l1_e;
        log_en = 1'b0;
        log_code = hit_code;
        log_dom = he.dom;
        case (st_r)
            S_IDLE: begin
                if (req) begin
                    acc_nxt = acc_in;
                    if (!mmu_on) begin
                        done_nxt = 1'b1;
                        pa_nxt = acc_in.va; // R6
                        cach_nxt = 1'b0;
                        buf_nxt = 1'b0;
                    end else begin
                        st_nxt = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                if (!hit) begin
                    st_nxt = S_L1; // R5
                    wreq_nxt = 1'b1;
                    waddr_nxt = l1_addr; // R14
                end else if (dom_fault || perm_fault) begin
                    abort_nxt = 1'b1; // R4 R24
                    log_en = 1'b1;
                    st_nxt = S_IDLE;
                end else begin
                    done_nxt = 1'b1; // R4
                    pa_nxt = pa_calc;
                    cach_nxt = he.cach && mmu_setup_r[SET_C]; // R17
                    buf_nxt = he.bufa && mmu_setup_r[SET_W]; // R17
                    st_nxt = S_IDLE;
                end
            end
            S_L1: begin
                if (walk_ack) begin
                    wreq_nxt = 1'b0;
                    if (walk_rdata[L1_SECT_BIT]) begin // R15
                        fill = 1'b1; // R16
                        st_nxt = S_CHECK;
                    end else if (walk_rdata[L1_PAGE_BIT]) begin
                        wreq_nxt = 1'b1; // R16
                        waddr_nxt = l2_addr;
                        l1dom_nxt = rd_dom;
                        st_nxt = S_L2;
                    end else begin
                        abort_nxt = 1'b1;
                        log_en = 1'b1;
                        log_code = FS_TRANS_SEC;
                        log_dom = rd_dom;
                        st_nxt = S_IDLE;
                    end
                end
            end
            S_L2: begin
                if (walk_ack) begin
                    wreq_nxt = 1'b0;
                    if (l2_type == L2_LARGE || l2_type == L2_SMALL) begin
                        fill = 1'b1;
                        fill_e = l2_e;
                        st_nxt = S_CHECK;
                    end else begin
                        abort_nxt = 1'b1;
                        log_en = 1'b1;
                        log_code = FS_TRANS_PAGE;
                        log_dom = l1_dom_r;
                        st_nxt = S_IDLE;
                    end
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            acc_r <= '0;
            ready_r <= 1'b1;
            done_r <= 1'b0;
            abort_r <= 1'b0;
            pa_r <= '0;
            cach_r <= 1'b0;
            buf_r <= 1'b0;
            walk_req_r <= 1'b0;
            walk_addr_r <= '0;
            l1_dom_r <= '0;
        end else begin
            st_r <= st_nxt;
            acc_r <= acc_nxt;
            ready_r <= st_nxt == S_IDLE;
            done_r <= done_nxt;
            abort_r <= abort_nxt;
            pa_r <= pa_nxt;
            cach_r <= cach_nxt;
            buf_r <= buf_nxt;
            walk_req_r <= wreq_nxt;
            walk_addr_r <= waddr_nxt;
            l1_dom_r <= l1dom_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= '0; // R25
            victim_r <= '0;
        end else begin
            valid_r <= valid_nxt;
            if (fill)
                victim_r <= victim_r + 1'b1; // R5
        end
    end

    // entry payload needs no reset, the valid bits guard it
    always_ff @(posedge clk) begin
        if (fill)
            tlb_r[victim_r] <= fill_e; // R5
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mmu_setup_r <= SETUP_RST;
            table_base_pointer_r <= ROOT_RST;
            zone_rights_r <= ZONE_RST;
            fault_cause_reg_r <= '0;
            fault_vaddr_reg_r <= '0;
            cp_rdata_r <= '0;
            cp_rvalid_r <= 1'b0;
        end else begin
            if (coproc_write_op && cp_reg == CP_SETUP)
                mmu_setup_r <= cp_wdata; // R7
            if (coproc_write_op && cp_reg == CP_ROOT)
                table_base_pointer_r <= {cp_wdata[31:ROOT_LSB],
                                         {ROOT_LSB{1'b0}}}; // R8
            if (coproc_write_op && cp_reg == CP_ZONE)
                zone_rights_r <= cp_wdata; // R9
            // prefetch faults may never be taken, so leave the log alone
            if (log_en && acc_r.data) begin // R13
                fault_cause_reg_r <= {log_dom, log_code}; // R10
                fault_vaddr_reg_r <= acc_r.va;
            end
            cp_rvalid_r <= coproc_read_op;
            if (coproc_read_op)
                cp_rdata_r <= rd_val; // R7
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_off_pass;
        st_r == S_IDLE && req && !mmu_on |=> done_r && pa_r == acc_r.va;
    endproperty
    a_off_pass: assert property (p_off_pass) // R6
        else $error("pass-through address wrong");

    property p_flush;
        cp_flush |=> valid_r == '0;
    endproperty
    a_flush: assert property (p_flush) // R11
        else $error("flush left an entry valid");

    property p_base_align;
        table_base_pointer_r[ROOT_LSB-1:0] == '0;
    endproperty
    a_base_align: assert property (p_base_align) // R8
        else $error("table base not aligned");

    property p_pref_hold;
        abort_r && !acc_r.data |->
            $stable(fault_cause_reg_r) && $stable(fault_vaddr_reg_r);
    endproperty
    a_pref_hold: assert property (p_pref_hold) // R13
        else $error("prefetch fault changed fault log");

    property p_l1_addr;
        st_r == S_L1 && walk_req_r |-> walk_addr_r ==
            {table_base_pointer_r[31:ROOT_LSB], acc_r.va[31:SEC_LSB],
             WORD_PAD};
    endproperty
    a_l1_addr: assert property (p_l1_addr) // R14
        else $error("level one address wrong");

    property p_no_dual;
        abort_r |-> !done_r ##1 !done_r;
    endproperty
    a_no_dual: assert property (p_no_dual) // R24
        else $error("aborted access reached memory");

    property p_victim;
        fill |=> victim_r == IDX_W'($past(victim_r) + 1'b1);
    endproperty
    a_victim: assert property (p_victim) // R5
        else $error("victim pointer did not step");

    property p_miss_walk;
        st_r == S_CHECK && !hit |=> walk_req_r && st_r == S_L1;
    endproperty
    a_miss_walk: assert property (p_miss_walk) // R5
        else $error("miss did not start a walk");

    property p_hit_grant;
        st_r == S_CHECK && hit && !dom_fault && !perm_fault |=>
            done_r && !abort_r && pa_r == $past(pa_calc);
    endproperty
    a_hit_grant: assert property (p_hit_grant) // R4
        else $error("granted hit not driven");

    c_hit_done: cover property (st_r == S_CHECK && hit ##1 done_r);
    c_abort: cover property (abort_r && acc_r.data);
    c_sec_fill: cover property (st_r == S_L1 && fill);
    c_page_walk: cover property (st_r == S_L2 && fill);
endmodule : mmu_translate_and_check

`default_nettype wire
